// ### ddr3_pdzq_core.sv
// Function
// (R1) Controller holds power-down at least tPD
// (R2) Controller waits tXP before refresh after exit
// (R3) Controller waits tXPDLL before next power-down
// (R4) Early entry after refresh: NOP until tRFC
// (R5) ACT/NOP/DES/open-bank PRE enter active power-down
// (R6) Long calibration used at init and anytime
// (R7) Completed calibration updates driver and termination
// (R8) First long calibration after reset gets tZQinit
// (R9) Later long calibrations get tZQoper
// (R10) Short calibration completes within tZQCS
// (R11) Short calibration corrects error within 64 cycles
// (R12) Controller keeps channel idle during calibration
// (R13) Calibration current path off when done
// (R14) Controller precharges all banks before calibration
// (R15) Calibration may overlap DLL lock after self-refresh
// (R16) No automatic calibration on self-refresh exit
// (R17) No calibration earlier than tXS after exit
// (R18) Shared resistor windows never overlap
// (R19) CKE held high during calibration
// (R20) Termination disabled during calibration
// (R21) DQ bus high impedance during calibration
// (R22) CKE edges with NOP/DES enter, exit power-down
// (R23) Open bank gives active, else precharge power-down
// (R24) Controller keeps timing counts as down-counters
`timescale 1ns/100ps
`include "pdzq_consts.svh"
module ddr3_pdzq_core
  import pdzq_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  input  wire logic       CLK_EN,
  input  wire logic       CKE,
  input  wire logic [3:0] CMD,
  input  wire logic [2:0] BANK,
  input  wire logic       ADDR_A10,
  input  wire logic       SREF_ENTRY,
  input  wire logic       ZQ_CMP_HI,
  output logic            PD_ACTIVE,
  output logic            PD_PRECHARGE,
  output logic            IN_SREF,
  output logic            ZQ_BUSY,
  output logic            ZQ_CUR_EN,
  output logic            ZQ_DONE,
  output logic [5:0]      DRV_CODE,
  output logic [5:0]      ODT_CODE,
  output logic            DQ_OE_N,
  output logic            CMD_VIOLATION
);
  logic            cke_s1_reg;
  logic            cke_s2_reg;
  logic            cke_prev_reg;
  logic [`BANKS-1:0] open_reg;
  pd_state_t       state_reg;
  logic            first_long_reg;
  logic            zq_start;
  zq_kind_t        zq_kind;
  logic            zq_busy_w;
  logic            zq_done_w;
  logic [5:0]      zq_code_w;
  logic            nop_like;
  logic            cmp_s1_reg;
  logic            cmp_s2_reg;

  // NOP and deselect are the only commands legal around power-down CKE edges and self-refresh exit
  function automatic logic is_nop(input logic [3:0] c);
    return (c == `CMD_NOP) || (c == `CMD_DES);
  endfunction

  // Two-stage synchroniser on CKE pin
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cke_s1_reg   <= 1'b0;
      cke_s2_reg   <= 1'b0;
      cke_prev_reg <= 1'b0;
    end else if (CLK_EN) begin
      cke_s1_reg   <= CKE;
      cke_s2_reg   <= cke_s1_reg;
      cke_prev_reg <= cke_s2_reg;
    end
  end

  // Comparator settles off the clock; two stages before the engine uses it
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else if (CLK_EN) begin
      cmp_s1_reg <= ZQ_CMP_HI;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  assign nop_like = is_nop(CMD);

  // Open-bank tracking
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      open_reg <= '0;
    end else if (CLK_EN && cke_s2_reg && state_reg == ST_IDLE) begin
      if (CMD == `CMD_ACT) begin
        open_reg[BANK] <= 1'b1;
      end else if (CMD == `CMD_PRE) begin
        if (ADDR_A10) begin
          open_reg <= '0;
        end else begin
          open_reg[BANK] <= 1'b0;
        end
      end
    end
  end

  // Power-down and self-refresh sequencing
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
    end else if (CLK_EN) begin
      case (state_reg)
        ST_IDLE: begin
          // Self-refresh request wins, even while calibrating; power-down entry while calibrating only flags a violation
          if (cke_prev_reg && !cke_s2_reg && SREF_ENTRY) begin
            state_reg <= ST_SREF;
          end else if (cke_prev_reg && !cke_s2_reg && nop_like && !zq_busy_w) begin
            if (open_reg != '0) begin
              state_reg <= ST_APD; // (R5) (R22) (R23)
            end else begin
              state_reg <= ST_PPD; // (R23)
            end
          end
        end
        ST_APD, ST_PPD: begin
          if (cke_s2_reg && nop_like) begin
            state_reg <= ST_IDLE; // (R22)
          end
        end
        ST_SREF: begin
          if (cke_s2_reg && nop_like) begin
            state_reg <= ST_IDLE; // (R16)
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Calibration command decode; only explicit commands start it
  always_comb begin
    zq_start = CLK_EN && cke_s2_reg && state_reg == ST_IDLE && CMD == `CMD_ZQ; // (R16) (R6)
    if (!ADDR_A10) begin
      zq_kind = ZQ_SHORT; // (R10)
    end else if (first_long_reg) begin
      zq_kind = ZQ_INIT; // (R8)
    end else begin
      zq_kind = ZQ_OPER; // (R9)
    end
  end

  // First long calibration after reset gets the init window
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      first_long_reg <= 1'b1;
    end else if (CLK_EN && zq_start && ADDR_A10 && !zq_busy_w) begin
      first_long_reg <= 1'b0; // (R8)
    end
  end

  // Window timing and code search
  zq_engine #(
    .CW (16)
  ) u_zq (
    .clk    (CORE_CLK),
    .rst_n  (RST_N),
    .ce     (CLK_EN),
    .start  (zq_start),
    .kind   (zq_kind),
    .cmp_hi (cmp_s2_reg),
    .busy   (zq_busy_w),
    .done   (zq_done_w),
    .code   (zq_code_w)
  );

  // Power-down status
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PD_ACTIVE    <= 1'b0;
      PD_PRECHARGE <= 1'b0;
      IN_SREF      <= 1'b0;
    end else if (CLK_EN) begin
      PD_ACTIVE    <= state_reg == ST_APD;
      PD_PRECHARGE <= state_reg == ST_PPD;
      IN_SREF      <= state_reg == ST_SREF;
    end
  end

  // Calibration status; this block never drives DQ
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ZQ_BUSY       <= 1'b0;
      ZQ_CUR_EN     <= 1'b0;
      ZQ_DONE       <= 1'b0;
      DQ_OE_N       <= 1'b1;
      CMD_VIOLATION <= 1'b0;
    end else if (CLK_EN) begin
      ZQ_BUSY      <= zq_busy_w;
      ZQ_CUR_EN    <= zq_busy_w; // (R13)
      ZQ_DONE      <= zq_done_w;
      DQ_OE_N      <= 1'b1;
      // Channel must stay quiet with CKE high while calibrating
      CMD_VIOLATION <= zq_busy_w && (!cke_s2_reg || !nop_like); // (R12) (R19)
    end
  end

  // Calibrated code reaches driver and termination together
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      DRV_CODE <= `ZQ_CODE_MID;
      ODT_CODE <= `ZQ_CODE_MID;
    end else if (CLK_EN) begin
      DRV_CODE <= zq_code_w; // (R7)
      ODT_CODE <= zq_code_w; // (R7)
    end
  end
endmodule

// ### pdzq_consts.svh
`ifndef PDZQ_CONSTS_SVH
`define PDZQ_CONSTS_SVH
`define CLK_PERIOD_NS     10
`define ZQCS_CYC          8'h40
`define ZQOPER_CYC        16'h0100
`define ZQINIT_CYC        16'h0200
`define ZQ_CORR_STEP      6'h01
`define ZQ_CODE_MID       6'h20
`define CMD_DES           4'hF
`define CMD_NOP           4'h7
`define CMD_ACT           4'h3
`define CMD_PRE           4'h2
`define CMD_REF           4'h1
`define CMD_ZQ            4'h6
`define ZQ_LONG_BIT       10
`define BANKS             8
`endif

// ### pdzq_pkg.sv
package pdzq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_APD    = 3'b001,
    ST_PPD    = 3'b010,
    ST_ZQ     = 3'b011,
    ST_SREF   = 3'b100
  } pd_state_t;
  typedef enum logic [1:0] {
    ZQ_NONE  = 2'b00,
    ZQ_INIT  = 2'b01,
    ZQ_OPER  = 2'b10,
    ZQ_SHORT = 2'b11
  } zq_kind_t;
endpackage

// ### zq_engine.sv
`timescale 1ns/100ps
`include "pdzq_consts.svh"
module zq_engine
  import pdzq_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          start,
  input  wire zq_kind_t      kind,
  input  wire logic          cmp_hi,
  output logic               busy,
  output logic               done,
  output logic [5:0]         code
);
  logic [CW-1:0] cnt_reg;
  logic [5:0]    work_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        case (kind)
          ZQ_INIT:  cnt_reg <= CW'(`ZQINIT_CYC);
          ZQ_OPER:  cnt_reg <= CW'(`ZQOPER_CYC);
          ZQ_SHORT: cnt_reg <= CW'(`ZQCS_CYC);
          default:  cnt_reg <= CW'(`ZQCS_CYC);
        endcase
      end else if (busy) begin
        if (cnt_reg == CW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end
  // Unit correction step each busy cycle; short run still spans the whole 6-bit code range
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      work_reg <= `ZQ_CODE_MID;
      code     <= `ZQ_CODE_MID;
    end else if (ce) begin
      if (busy && cmp_hi && work_reg != 6'h3F) begin
        work_reg <= work_reg + `ZQ_CORR_STEP; // (R11)
      end else if (busy && !cmp_hi && work_reg != 6'h00) begin
        work_reg <= work_reg - `ZQ_CORR_STEP; // (R11)
      end
      if (busy && cnt_reg == CW'(1)) begin
        code <= work_reg; // (R7)
      end
    end
  end
endmodule

// ### ddr3_pdzq_core_asserts.sv
`timescale 1ns/100ps
module ddr3_pdzq_core_chk (
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  input  wire logic       CLK_EN,
  input  wire logic       PD_ACTIVE,
  input  wire logic       PD_PRECHARGE,
  input  wire logic       ZQ_BUSY,
  input  wire logic       ZQ_CUR_EN,
  input  wire logic       ZQ_DONE,
  input  wire logic [5:0] DRV_CODE,
  input  wire logic [5:0] ODT_CODE,
  input  wire logic       DQ_OE_N
);
  logic [9:0] blen_reg;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Length of the current calibration window
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !ZQ_BUSY) blen_reg <= 10'h000;
    else if (CLK_EN) blen_reg <= blen_reg + 10'h001;
  end
  property p_len; $fell(ZQ_BUSY) |-> blen_reg inside {10'h040, 10'h100, 10'h200}; endproperty
  a_len: assert property (p_len) else $error("zq window length");
  property p_done; $fell(ZQ_BUSY) |-> ##[0:2] ZQ_DONE; endproperty
  a_done: assert property (p_done) else $error("zq done missing");
  property p_pulse; ZQ_DONE && CLK_EN |=> !ZQ_DONE; endproperty
  a_pulse: assert property (p_pulse) else $error("zq done too long");
  property p_code; $changed(DRV_CODE) |-> ##[0:4] $past(ZQ_DONE, 2); endproperty
  a_code: assert property (p_code) else $error("code moved off done");
  property p_odt; ODT_CODE == DRV_CODE; endproperty
  a_odt: assert property (p_odt) else $error("odt code differs");
  property p_cur; ZQ_CUR_EN == ZQ_BUSY; endproperty
  a_cur: assert property (p_cur) else $error("current path");
  property p_dq; DQ_OE_N; endproperty
  a_dq: assert property (p_dq) else $error("dq driven");
  property p_nopd; ZQ_BUSY |-> !PD_ACTIVE && !PD_PRECHARGE; endproperty
  a_nopd: assert property (p_nopd) else $error("pd while busy");
  property p_pdx; !(PD_ACTIVE && PD_PRECHARGE); endproperty
  a_pdx: assert property (p_pdx) else $error("both pd states");
endmodule
bind ddr3_pdzq_core ddr3_pdzq_core_chk u_chk (.CORE_CLK, .RST_N, .CLK_EN, .PD_ACTIVE,
  .PD_PRECHARGE, .ZQ_BUSY, .ZQ_CUR_EN, .ZQ_DONE, .DRV_CODE, .ODT_CODE, .DQ_OE_N);

// ### ddr3_ctrl_model.sv
`timescale 1ns/100ps
`include "pdzq_consts.svh"
module ddr3_ctrl_model #(
  parameter int T_RP = 4,
  parameter int T_PD = 8
) (
  input  wire logic       clk,
  output logic            cke,
  output logic [3:0]      cmd,
  output logic            a10,
  output logic [2:0]      bank,
  output logic            sref
);
  initial begin
    cke = 1'b1;
    cmd = `CMD_DES;
    a10 = 1'b0;
    bank = 3'h0;
    sref = 1'b0;
  end
  task automatic issue(input logic [3:0] c, input logic a, input int n);
    cmd <= c;
    a10 <= a;
    bank <= 3'($urandom);
    @(posedge clk);
    cmd <= `CMD_NOP;
    repeat (n) @(posedge clk);
  endtask
  task automatic zq(input logic lng, input int n);
    issue(`CMD_PRE, 1'b1, T_RP);
    issue(`CMD_ZQ, lng, n);
  endtask
  task automatic enter(input logic s);
    cke <= 1'b0;
    sref <= s;
    repeat (T_PD) @(posedge clk);
    sref <= 1'b0;
  endtask
  task automatic leave(input int n);
    cke <= 1'b1;
    repeat (n) @(posedge clk);
  endtask
endmodule

// ### tb_ddr3_pdzq_core.sv
`timescale 1ns/100ps
`include "pdzq_consts.svh"
module tb_ddr3_pdzq_core;
  logic       clk;
  logic       rst_n;
  logic       clk_en;
  logic       cmp_hi;
  logic       cke;
  logic       a10;
  logic       sref;
  logic [3:0] cmd;
  logic [2:0] bank;
  logic       pd_act;
  logic       pd_pre;
  logic       in_sref;
  logic       busy;
  logic       viol;
  logic       vseen;
  logic       first;
  logic [5:0] drv;
  logic [5:0] old;
  logic [5:0] odt;
  logic       cur;
  logic       done;
  logic       oe_n;
  int         err_total;
  int         cmp_count;
  int         cyc;
  int         blen;
  int         clen;
  int         dcnt;
  ddr3_ctrl_model m (.clk(clk), .cke(cke), .cmd(cmd), .a10(a10), .bank(bank), .sref(sref));
  ddr3_pdzq_core dut (
    .CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .CKE(cke), .CMD(cmd), .BANK(bank),
    .ADDR_A10(a10), .SREF_ENTRY(sref), .ZQ_CMP_HI(cmp_hi), .PD_ACTIVE(pd_act),
    .PD_PRECHARGE(pd_pre), .IN_SREF(in_sref), .ZQ_BUSY(busy), .ZQ_CUR_EN(cur), .ZQ_DONE(done),
    .DRV_CODE(drv), .ODT_CODE(odt), .DQ_OE_N(oe_n), .CMD_VIOLATION(viol));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("mismatches %0d of %0d compares", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (busy === 1'b1) blen++;
    if (cur === 1'b1) clen++;
    if (done === 1'b1) dcnt++;
    if (viol === 1'b1) vseen = 1'b1;
    if (cyc == 4000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int exp_len(input logic lng, input logic fst);
    return lng ? (fst ? `ZQINIT_CYC : `ZQOPER_CYC) : `ZQCS_CYC;
  endfunction
  // A window of 64 or more unit steps walks the code from any value to a rail
  function automatic logic [5:0] exp_code(input logic hi);
    return hi ? 6'h3F : 6'h00;
  endfunction
  task automatic cal(input logic lng);
    int n;
    n = exp_len(lng, first);
    blen = 0;
    clen = 0;
    dcnt = 0;
    old = drv;
    m.zq(lng, n + 8);
    chk(16'(blen), 16'(n));
    chk(16'(clen), 16'(n));
    chk(16'(dcnt), 16'h0001);
    if (lng) first = 1'b0;
  endtask
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    cmp_hi = 1'b1;
    first = 1'b1;
    vseen = 1'b0;
    void'($urandom(96647));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(16'(drv), 16'(`ZQ_CODE_MID));
    cal(1'b1);
    chk(16'(drv >= old), 16'h1);
    chk(16'(oe_n), 16'h0001);
    chk(16'(vseen), 16'h0);
    // Second long command lands mid-window and must be ignored
    blen = 0;
    m.issue(`CMD_PRE, 1'b1, 4);
    m.issue(`CMD_ZQ, 1'b1, 100);
    m.issue(`CMD_ZQ, 1'b1, 300);
    chk(16'(vseen), 16'h1);
    chk(16'(blen), `ZQOPER_CYC);
    repeat (4) begin
      cmp_hi <= 1'($urandom);
      @(posedge clk);
      cal(1'b0);
      chk(16'(drv), 16'(exp_code(cmp_hi)));
      chk(16'(odt), 16'(exp_code(cmp_hi)));
    end
    m.issue(`CMD_PRE, 1'b1, 4);
    m.enter(1'b0);
    chk(16'(pd_pre), 16'h1);
    m.leave(6);
    chk(16'(pd_pre), 16'h0);
    m.issue(`CMD_REF, 1'b0, 12);
    m.issue(`CMD_ACT, 1'b0, 4);
    m.enter(1'b0);
    chk(16'(pd_act), 16'h1);
    m.leave(6);
    chk(16'(pd_act), 16'h0);
    m.issue(`CMD_PRE, 1'b1, 4);
    m.enter(1'b1);
    chk(16'(in_sref), 16'h1);
    m.leave(20);
    chk(16'(busy), 16'h0);
    cal(1'b0);
    // Clock enable low mid-window freezes the calibration count
    blen = 0;
    dcnt = 0;
    m.issue(`CMD_PRE, 1'b1, 4);
    m.issue(`CMD_ZQ, 1'b0, 20);
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    clk_en <= 1'b1;
    repeat (60) @(posedge clk);
    chk(16'(blen), 16'(`ZQCS_CYC) + 16'h000A);
    chk(16'(dcnt), 16'h0001);
    // Reset mid-run: the next long command is again the first
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    first = 1'b1;
    @(posedge clk);
    chk(16'(drv), 16'(`ZQ_CODE_MID));
    cal(1'b1);
    end_of_test();
  end
endmodule
